//--- dv/leib_host_model.sv
/* Host processor model: register reads, writes, flag clearing.
   Assumes the plain register port with read data one cycle late. */
`timescale 1ns/100ps
module leib_host_model
  import leib_pkg::*;
(
  input wire logic mclk_i,
  input wire logic [31:0] rdata_i,
  output leib_pkg::leib_bus_req_t req_o
);
  logic [31:0] last;
  initial req_o = '0;
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    req_o <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_i);
    req_o <= '0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk_i);
    req_o <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_i);
    req_o <= '0;
    @(posedge mclk_i);
    v = rdata_i;
  endtask : rd_reg
  // Write back exactly what was read, so late events survive
  task automatic clr_flags();
    rd_reg(LEIB_EVENT_STATUS_OFS, last);
    wr_reg(LEIB_EVENT_STATUS_OFS, last);
  endtask : clr_flags
endmodule : leib_host_model

//--- dv/leib_tb_top.sv
/* Self-checking bench for the link event flag block.
   Assumes leib_top, the host model and the bound checker. */
`timescale 1ns/100ps
module leib_tb_top;
  import leib_pkg::*;
  localparam logic [7:0] ST = LEIB_EVENT_STATUS_OFS;
  localparam logic [7:0] MK = LEIB_EVENT_MASK_OFS;
  localparam logic [7:0] CT = LEIB_CONTROL_OFS;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [14:0] ev = '0;
  logic ten = 1'b1, node = 1'b1, areq = 1'b0, ireq = 1'b0;
  leib_bus_req_t req;
  logic [31:0] rdata, d;
  logic agnt, ignt, bsy, disc, flt, irq;
  int mismatches = 0, checks = 0, cyc = 0;
  always #5 mclk_i = ~mclk_i;
  leib_host_model u_leib_host_model (.mclk_i(mclk_i), .rdata_i(rdata), .req_o(req));
  leib_top u_leib_top (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(req.addr), .wdata_i(req.wdata),
    .wr_i(req.wr), .rd_i(req.rd), .rdata_o(rdata), .iso_tx_format_error_i(ev[0]),
    .async_tx_format_error_i(ev[1]), .async_first_quadlet_miss_i(ev[2]), .async_tx_fifo_underflow_i(ev[3]),
    .general_receive_fifo_overflow_i(ev[4]), .rx_packet_for_node_i(node), .header_crc_error_i(ev[5]),
    .tcode_invalid_i(ev[6]), .cycle_overrun_i(ev[7]), .seconds_inc_i(ev[8]), .cycle_timer_enable_i(ten),
    .cycle_start_seen_i(ev[9]), .subaction_gap_i(ev[10]), .arbitration_gap_i(ev[11]), .offset_zero_i(ev[12]),
    .cycle_start_arb_fail_i(ev[13]), .iso_arb_fail_i(ev[14]), .async_tx_req_i(areq), .iso_tx_req_i(ireq),
    .async_tx_grant_o(agnt), .iso_tx_grant_o(ignt), .busy_ack_o(bsy), .packet_discard_o(disc),
    .async_fault_o(flt), .irq_o(irq));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test();
    if (mismatches == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    u_leib_host_model.rd_reg(a, v);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    u_leib_host_model.wr_reg(a, v);
  endtask : wr
  task automatic pulse(input int i);
    @(posedge mclk_i);
    ev[i] <= 1'b1;
    @(posedge mclk_i);
    ev <= '0;
  endtask : pulse
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(ST, d);
    chk(d, LEIB_EVENT_STATUS_RST);
    rd(MK, d);
    chk(d, LEIB_EVENT_MASK_RST);
    rd(CT, d);
    chk(d, 32'(LEIB_CONTROL_RST));
    rd(8'hF0, d);
    chk(d, 32'h0);
  endtask : t_reset
  // Cycle start last: it leaves a cycle open for the next scenario
  task automatic t_events();
    int ei[12] = '{0, 1, 4, 5, 6, 7, 8, 10, 11, 13, 14, 9};
    int eb[12] = '{11, 12, 14, 15, 16, 19, 20, 30, 29, 25, 31, 21};
    for (int k = 0; k < 12; k++) begin
      pulse(ei[k]);
      rd(ST, d);
      chk(d, 32'h1 << eb[k]);
      u_leib_host_model.clr_flags();
      rd(ST, d);
      chk(d, 32'h0);
    end
    ten <= 1'b0;
    pulse(8);
    rd(ST, d);
    chk(d, 32'h0);
    ten <= 1'b1;
  endtask : t_events
  task automatic t_cycle();
    pulse(12);
    u_leib_host_model.clr_flags();
    rd(ST, d);
    chk(d, 32'h0080_0000);
    pulse(9);
    pulse(10);
    rd(ST, d);
    chk(d, 32'h4060_0000);
    u_leib_host_model.clr_flags();
    wr(CT, 32'h2);
    pulse(12);
    pulse(12);
    wr(CT, 32'h0);
    rd(ST, d);
    chk(d, 32'h0080_0000);
    pulse(12);
    pulse(12);
    pulse(9);
    pulse(10);
    rd(ST, d);
    chk(d, 32'h4160_0000);
    u_leib_host_model.clr_flags();
  endtask : t_cycle
  task automatic t_fault();
    areq <= 1'b1;
    ireq <= 1'b1;
    for (int j = 2; j < 4; j++) begin
      pulse(j);
      @(posedge mclk_i);
      chk(32'(flt), 32'h1);
      chk(32'(agnt), 32'h0);
      chk(32'(ignt), 32'h1);
      u_leib_host_model.clr_flags();
      chk(u_leib_host_model.last, 32'h0000_1000);
      chk(32'(flt), 32'h1);
      wr(LEIB_FIFO_CLEAR_OFS, 32'h1);
      repeat (2) @(posedge mclk_i);
      chk(32'(flt), 32'h0);
      chk(32'(agnt), 32'h1);
    end
    areq <= 1'b0;
    ireq <= 1'b0;
  endtask : t_fault
  task automatic t_busy();
    pulse(4);
    @(posedge mclk_i);
    chk(32'(bsy), 32'h1);
    pulse(5);
    @(posedge mclk_i);
    chk(32'(disc), 32'h1);
    u_leib_host_model.clr_flags();
    chk(u_leib_host_model.last, 32'h0000_C000);
    repeat (2) @(posedge mclk_i);
    chk(32'(bsy), 32'h0);
    node <= 1'b0;
    pulse(4);
    @(posedge mclk_i);
    chk(32'(bsy), 32'h0);
    pulse(5);
    @(posedge mclk_i);
    chk(32'(disc), 32'h0);
    rd(ST, d);
    chk(d, 32'h0000_4000);
    u_leib_host_model.clr_flags();
    node <= 1'b1;
  endtask : t_busy
  task automatic t_irq();
    wr(MK, 32'hFFFF_FFFF);
    rd(MK, d);
    chk(d, LEIB_EVENT_IMPL);
    pulse(14);
    rd(ST, d);
    chk(d, 32'h8000_0001);
    chk(32'(irq), 32'h0);
    wr(CT, 32'h1);
    repeat (2) @(posedge mclk_i);
    chk(32'(irq), 32'h1);
    wr(ST, 32'hFFFF_FFFF);
    rd(ST, d);
    chk(d, 32'h0);
    chk(32'(irq), 32'h0);
    wr(CT, 32'h0);
    wr(MK, 32'h0);
  endtask : t_irq
  initial begin
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    t_reset();
    t_events();
    t_cycle();
    t_fault();
    t_busy();
    t_irq();
    end_of_test();
  end
  // Whole run needs about 320 cycles
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      end_of_test();
    end
  end
endmodule : leib_tb_top

//--- dv/leib_top_assertions.sv
/* Port checker for the link event flag block.
   Assumes it is bound onto leib_top, one clock domain. */
`timescale 1ns/100ps
module leib_top_assertions
  import leib_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic async_tx_format_error_i,
  input wire logic async_first_quadlet_miss_i,
  input wire logic async_tx_fifo_underflow_i,
  input wire logic general_receive_fifo_overflow_i,
  input wire logic rx_packet_for_node_i,
  input wire logic header_crc_error_i,
  input wire logic iso_tx_req_i,
  input wire logic async_tx_grant_o,
  input wire logic iso_tx_grant_o,
  input wire logic busy_ack_o,
  input wire logic packet_discard_o,
  input wire logic async_fault_o,
  input wire logic irq_o
);
  logic clr_hit;
  logic gate_reg;
  assign clr_hit = wr_i && addr_i == LEIB_FIFO_CLEAR_OFS && wdata_i[LEIB_ASYNC_FIFO_CLEAR_BIT];
  // Gate mirrored from writes, since the checker sees ports only
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_reg <= 1'b0;
    end else if (wr_i && addr_i == LEIB_CONTROL_OFS) begin
      gate_reg <= wdata_i[LEIB_GLOBAL_IRQ_GATE_BIT];
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence fault_in_s;
    async_first_quadlet_miss_i || async_tx_fifo_underflow_i;
  endsequence
  sequence quiet_s;
    !async_first_quadlet_miss_i && !async_tx_fifo_underflow_i && !async_tx_format_error_i;
  endsequence
  fault_entry_a: assert property (fault_in_s |=> async_fault_o)
    else $error("fault not entered");
  fault_hold_a: assert property (async_fault_o && !clr_hit && !$past(clr_hit) |=> async_fault_o)
    else $error("fault left without clear");
  fault_exit_a: assert property (clr_hit ##0 quiet_s ##1 quiet_s |=> !async_fault_o)
    else $error("fault kept after clear");
  async_block_a: assert property (async_fault_o |-> !async_tx_grant_o)
    else $error("async grant in fault");
  iso_grant_a: assert property (async_fault_o && iso_tx_req_i |=> iso_tx_grant_o)
    else $error("iso blocked in fault");
  busy_ack_a: assert property (general_receive_fifo_overflow_i && rx_packet_for_node_i |=> busy_ack_o)
    else $error("no busy ack");
  discard_pkt_a: assert property (header_crc_error_i && rx_packet_for_node_i |=> packet_discard_o)
    else $error("packet not discarded");
  busy_foreign_a: assert property (!rx_packet_for_node_i |=> !busy_ack_o)
    else $error("busy ack to foreign packet");
  discard_foreign_a: assert property (!rx_packet_for_node_i |=> !packet_discard_o)
    else $error("foreign packet discarded");
  reserved_zero_a: assert property (rd_i && addr_i == LEIB_EVENT_STATUS_OFS |=>
    (rdata_o & ~(LEIB_EVENT_IMPL | 32'h1)) == 32'h0)
    else $error("reserved bit read one");
  irq_gate_a: assert property (irq_o |-> $past(gate_reg))
    else $error("irq without gate");
endmodule : leib_top_assertions

bind leib_top leib_top_assertions u_leib_top_assertions (.*);

//--- hdl/leib_event_bit.sv
/*
  One sticky event flag with set-over-clear priority.
  Assumes set and clear pulses synchronous to the block clock.
*/
`timescale 1ns/100ps
module leib_event_bit (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic set_i,
  input wire logic clear_i,
  output logic flag_o
);

  // ----------------------------------------
  // Flag
  // ----------------------------------------
  // Set wins so an event in the clear cycle is kept
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clear_i) begin
      flag_o <= 1'b0;
    end
  end

endmodule : leib_event_bit

//--- hdl/leib_pkg.sv
/*
  Package for the link event flag block: register offsets, bit positions,
  reset values and the bus request carrier.
  Assumes a 32-bit plain register port with byte offsets on word boundaries.
*/
package leib_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] LEIB_EVENT_STATUS_OFS = 8'h0C;
  localparam logic [7:0] LEIB_EVENT_MASK_OFS = 8'h10;
  localparam logic [7:0] LEIB_CONTROL_OFS = 8'h40;
  localparam logic [7:0] LEIB_FIFO_CLEAR_OFS = 8'h1C;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int LEIB_SUMMARY_BIT = 0;
  localparam int LEIB_ISO_TX_FORMAT_ERROR_BIT = 11;
  localparam int LEIB_ASYNC_TX_FORMAT_ERROR_BIT = 12;
  localparam int LEIB_BUSY_ACK_SENT_BIT = 14;
  localparam int LEIB_HEADER_CRC_ERROR_BIT = 15;
  localparam int LEIB_TCODE_INVALID_BIT = 16;
  localparam int LEIB_CYCLE_OVERRUN_BIT = 19;
  localparam int LEIB_SECONDS_TICK_BIT = 20;
  localparam int LEIB_CYCLE_STARTED_BIT = 21;
  localparam int LEIB_CYCLE_DONE_BIT = 22;
  localparam int LEIB_CYCLE_PENDING_BIT = 23;
  localparam int LEIB_CYCLE_LOST_BIT = 24;
  localparam int LEIB_CYCLE_START_ARB_FAIL_BIT = 25;
  localparam int LEIB_ARBITRATION_GAP_EVENT_BIT = 29;
  localparam int LEIB_SUBACTION_GAP_EVENT_BIT = 30;
  localparam int LEIB_ISO_ARB_FAIL_BIT = 31;
  localparam int LEIB_GLOBAL_IRQ_GATE_BIT = 0;
  localparam int LEIB_CYCLE_MASTER_BIT = 1;
  localparam int LEIB_ASYNC_FIFO_CLEAR_BIT = 0;
  localparam int LEIB_ROLLOVER_LIMIT = 2;

  // Implemented event bits: 11,12,14,15,16,19..25,29..31
  localparam logic [31:0] LEIB_EVENT_IMPL = 32'hE3F9_D800;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [31:0] LEIB_EVENT_STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] LEIB_EVENT_MASK_RST = 32'h0000_0000;
  localparam logic [1:0] LEIB_CONTROL_RST = 2'h0;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } leib_bus_req_t;

  typedef enum logic [1:0] {
    LEIB_ASYNC_OK = 2'b00,
    LEIB_ASYNC_FAULT = 2'b01
  } leib_async_state_t;

endpackage : leib_pkg

//--- hdl/leib_top.sv
/*
  Upper event flags of the link controller, their mask, the summary bit,
  the gated interrupt output and the async transmit fault state.
  Assumes event inputs are one-cycle pulses from transmitter, receiver and
  cycle timer logic, all on mclk_i.
*/
// Our own choices: strobed register access and the address map.
// Notes on behaviour
// R1: Iso transmit FIFO invalid data sets flag bit 11.
// R2: Async transmit FIFO invalid data sets flag bit 12.
// R3: First quadlet not at first-quadlet entry enters fault, sets bit 12.
// R4: Async FIFO underflow during transmission enters fault, sets bit 12.
// R5: In fault no async packets go; async FIFO clear bit leaves it.
// R6: Iso transmission continues normally during async fault.
// R7: General receive FIFO overflow sets busy-sent flag bit 14.
// R8: After overflow, packets to this node get busy acknowledge.
// R9: Header CRC error on possibly-ours packet sets bit 15, discards packet.
// R10: Invalid transaction code from transmit FIFO sets bit 16.
// R11: Cycle longer than nominal period sets bit 19. Here bit 19 is in LEIB_EVENT_IMPL and is cleared like the other flags.
// R12: Seconds field increment with timer enabled sets bit 20.
// R13: Cycle-start sent or received sets bit 21.
// R14: Subaction gap after cycle start sets bit 22.
// R15: Offset reaching zero sets bit 23, held until cycle ends.
// R16: Not cycle master, two rollovers without cycle start set bit 24.
// R17: Cycle-start arbitration failure sets bit 25.
// R18: Isochronous arbitration failure sets bit 31.
// R19: Arbitration gap sets bit 29, subaction gap sets bit 30.
// R20: Bits 13, 17-18, 26-28 read zero, ignore writes.
// R21: Bit 0 is OR of event bits ANDed with their masks.
// R22: Writing ones to event register clears those flags; bit 23 ignores such writes and clears only at cycle end.
// R23: Interrupt output needs summary bit and global gate both set.
`timescale 1ns/100ps
module leib_top #(
  parameter int DATA_W = 32
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic iso_tx_format_error_i,
  input wire logic async_tx_format_error_i,
  input wire logic async_first_quadlet_miss_i,
  input wire logic async_tx_fifo_underflow_i,
  input wire logic general_receive_fifo_overflow_i,
  input wire logic rx_packet_for_node_i,
  input wire logic header_crc_error_i,
  input wire logic tcode_invalid_i,
  input wire logic cycle_overrun_i,
  input wire logic seconds_inc_i,
  input wire logic cycle_timer_enable_i,
  input wire logic cycle_start_seen_i,
  input wire logic subaction_gap_i,
  input wire logic arbitration_gap_i,
  input wire logic offset_zero_i,
  input wire logic cycle_start_arb_fail_i,
  input wire logic iso_arb_fail_i,
  input wire logic async_tx_req_i,
  input wire logic iso_tx_req_i,
  output logic async_tx_grant_o,
  output logic iso_tx_grant_o,
  output logic busy_ack_o,
  output logic packet_discard_o,
  output logic async_fault_o,
  output logic irq_o
);
  import leib_pkg::*;

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (DATA_W != 32) begin : g_bad_width
    $error("leib_top: DATA_W must be 32");
  end

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  leib_bus_req_t bus;
  logic wr_status;
  logic wr_mask;
  logic wr_control;
  logic wr_fifo_clear;
  logic async_fifo_clear;

  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign wr_status = bus.wr && (bus.addr == LEIB_EVENT_STATUS_OFS);
  assign wr_mask = bus.wr && (bus.addr == LEIB_EVENT_MASK_OFS);
  assign wr_control = bus.wr && (bus.addr == LEIB_CONTROL_OFS);
  assign wr_fifo_clear = bus.wr && (bus.addr == LEIB_FIFO_CLEAR_OFS);
  // Self clearing: the strobe itself is the clear pulse
  assign async_fifo_clear = wr_fifo_clear && bus.wdata[LEIB_ASYNC_FIFO_CLEAR_BIT];

  // ----------------------------------------
  // Mask and control
  // ----------------------------------------
  logic [31:0] mask_reg;
  logic [1:0] control_reg;

  always_ff @(posedge mclk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      mask_reg <= LEIB_EVENT_MASK_RST;
    end else if (wr_mask) begin
      mask_reg <= bus.wdata & LEIB_EVENT_IMPL;  // R20
    end
  end

  always_ff @(posedge mclk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      control_reg <= LEIB_CONTROL_RST;
    end else if (wr_control) begin
      control_reg <= bus.wdata[1:0];
    end
  end

  // ----------------------------------------
  // Async fault state
  // ----------------------------------------
  leib_async_state_t async_state_reg;
  logic async_fault_entry;

  assign async_fault_entry = async_first_quadlet_miss_i || async_tx_fifo_underflow_i;  // R3 R4

  always_ff @(posedge mclk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      async_state_reg <= LEIB_ASYNC_OK;
    end else begin
      unique case (async_state_reg)
        LEIB_ASYNC_OK: begin
          if (async_fault_entry) begin
            async_state_reg <= LEIB_ASYNC_FAULT;  // R3 R4
          end
        end
        LEIB_ASYNC_FAULT: begin
          // New fault in the clear cycle keeps the state
          if (async_fifo_clear && !async_fault_entry) begin
            async_state_reg <= LEIB_ASYNC_OK;  // R5
          end
        end
        default: begin
          async_state_reg <= LEIB_ASYNC_FAULT;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Cycle tracking
  // ----------------------------------------
  logic in_cycle_reg;
  logic pending_reg;
  logic [1:0] rollover_cnt_reg;
  logic cycle_end;

  // Cycle ends at the first subaction gap after a cycle start
  assign cycle_end = in_cycle_reg && subaction_gap_i;  // R14

  always_ff @(posedge mclk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      in_cycle_reg <= 1'b0;
    end else if (cycle_start_seen_i) begin
      in_cycle_reg <= 1'b1;
    end else if (cycle_end) begin
      in_cycle_reg <= 1'b0;
    end
  end

  // Pending follows hardware only; software writes cannot drop it early
  always_ff @(posedge mclk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      pending_reg <= 1'b0;
    end else if (offset_zero_i) begin
      pending_reg <= 1'b1;  // R15
    end else if (cycle_end) begin
      pending_reg <= 1'b0;  // R15
    end
  end

  always_ff @(posedge mclk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      rollover_cnt_reg <= 2'h0;
    end else if (cycle_start_seen_i || control_reg[LEIB_CYCLE_MASTER_BIT]) begin
      rollover_cnt_reg <= 2'h0;
    end else if (offset_zero_i && rollover_cnt_reg < 2'(LEIB_ROLLOVER_LIMIT)) begin
      rollover_cnt_reg <= rollover_cnt_reg + 2'h1;
    end
  end

  logic cycle_lost_set;
  assign cycle_lost_set = !control_reg[LEIB_CYCLE_MASTER_BIT] && !cycle_start_seen_i && offset_zero_i
                          && (rollover_cnt_reg == 2'(LEIB_ROLLOVER_LIMIT - 1));  // R16

  // ----------------------------------------
  // Event flags
  // ----------------------------------------
  logic [31:0] set_vec;
  logic [31:0] flags;

  always_comb begin
    set_vec = 32'h0000_0000;
    set_vec[LEIB_ISO_TX_FORMAT_ERROR_BIT] = iso_tx_format_error_i;  // R1
    set_vec[LEIB_ASYNC_TX_FORMAT_ERROR_BIT] = async_tx_format_error_i || async_fault_entry;  // R2 R3 R4
    set_vec[LEIB_BUSY_ACK_SENT_BIT] = general_receive_fifo_overflow_i;  // R7
    set_vec[LEIB_HEADER_CRC_ERROR_BIT] = header_crc_error_i && rx_packet_for_node_i;  // R9
    set_vec[LEIB_TCODE_INVALID_BIT] = tcode_invalid_i;  // R10
    set_vec[LEIB_CYCLE_OVERRUN_BIT] = cycle_overrun_i;  // R11
    set_vec[LEIB_SECONDS_TICK_BIT] = seconds_inc_i && cycle_timer_enable_i;  // R12
    set_vec[LEIB_CYCLE_STARTED_BIT] = cycle_start_seen_i;  // R13
    set_vec[LEIB_CYCLE_DONE_BIT] = cycle_end;  // R14
    set_vec[LEIB_CYCLE_LOST_BIT] = cycle_lost_set;  // R16
    set_vec[LEIB_CYCLE_START_ARB_FAIL_BIT] = cycle_start_arb_fail_i;  // R17
    set_vec[LEIB_ARBITRATION_GAP_EVENT_BIT] = arbitration_gap_i;  // R19
    set_vec[LEIB_SUBACTION_GAP_EVENT_BIT] = subaction_gap_i;  // R19
    set_vec[LEIB_ISO_ARB_FAIL_BIT] = iso_arb_fail_i;  // R18
  end

  for (genvar b = 0; b < 32; b++) begin : g_flag
    if (LEIB_EVENT_IMPL[b] && b != LEIB_CYCLE_PENDING_BIT) begin : g_impl
      leib_event_bit u_bit (
        .clk_i(mclk_i),
        .rst_n_i(rst_sync_reg),
        .set_i(set_vec[b]),
        .clear_i(wr_status && bus.wdata[b]),  // R22
        .flag_o(flags[b])
      );
    end else if (b == LEIB_CYCLE_PENDING_BIT) begin : g_pend
      assign flags[b] = pending_reg;
    end else begin : g_rsvd
      assign flags[b] = 1'b0;  // R20
    end
  end

  // ----------------------------------------
  // Summary, interrupt and outputs
  // ----------------------------------------
  logic summary;
  logic [31:0] status_word;

  assign summary = |(flags & mask_reg & LEIB_EVENT_IMPL);  // R21
  assign status_word = {flags[31:1], summary};

  always_ff @(posedge mclk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= summary && control_reg[LEIB_GLOBAL_IRQ_GATE_BIT];  // R23
    end
  end

  always_ff @(posedge mclk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      rdata_o <= 32'h0000_0000;
    end else if (bus.rd) begin
      unique case (bus.addr)
        LEIB_EVENT_STATUS_OFS: rdata_o <= status_word;
        LEIB_EVENT_MASK_OFS: rdata_o <= mask_reg;
        LEIB_CONTROL_OFS: rdata_o <= {30'h0000_0000, control_reg};
        default: rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

  // Grants are registered: a request answers one cycle later
  always_ff @(posedge mclk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      async_tx_grant_o <= 1'b0;
      iso_tx_grant_o <= 1'b0;
      async_fault_o <= 1'b0;
    end else begin
      async_tx_grant_o <= async_tx_req_i && (async_state_reg == LEIB_ASYNC_OK) && !async_fault_entry;  // R5
      iso_tx_grant_o <= iso_tx_req_i;  // R6
      async_fault_o <= (async_state_reg == LEIB_ASYNC_FAULT) || async_fault_entry;
    end
  end

  // Busy ack persists until software clears the busy-sent flag
  always_ff @(posedge mclk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      busy_ack_o <= 1'b0;
      packet_discard_o <= 1'b0;
    end else begin
      busy_ack_o <= rx_packet_for_node_i && (flags[LEIB_BUSY_ACK_SENT_BIT] || general_receive_fifo_overflow_i);  // R8
      packet_discard_o <= header_crc_error_i && rx_packet_for_node_i;  // R9
    end
  end

endmodule : leib_top
